// file: design/fsr_flash_end.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - opcode 09h shifts out second status byte
// - repeat second byte while chip select low
// - host polls busy bit during suspend/resume
// - bit 0 mirrors first-byte busy bit
// - erase-suspended set on suspend, cleared on resume
// - program-suspended set on suspend, cleared resume
// - program failure or protected target sets bit5
// - erase failure or protected target sets bit6
// - new program/erase instruction clears failure flags
// - positions 1, 4, 7 read zero
// - host masks reserved positions when testing
// - volatile bits zero after reset, read-only
// - opcode 95h streams third byte repeatedly
// - both reads work on four lines too
// - bits 3:2 report output drive strength
// - bits 5:4 dummy code, default 00
// - quad mode: two clocks per dummy byte
// - third byte positions 7,6,1,0 reserved
// - fast reads: 3 unaligned, 2 aligned
module fsr_flash_end (
    input  wire logic                clk,
    input  wire logic                sys_rst,
    fsr_spi_if.device                bus,
    input  wire logic                write_in_progress,
    input  wire logic                erase_suspend,
    input  wire logic                erase_resume,
    input  wire logic                program_suspend,
    input  wire logic                program_resume,
    input  wire logic                program_fail,
    input  wire logic                erase_fail,
    input  wire logic                program_protected,
    input  wire logic                erase_protected,
    input  wire logic                fail_clear,
    input  wire logic [1:0]          dummy_code,
    input  wire logic [1:0]          drive_code,
    output var  logic [7:0]          second_status_byte,
    output var  logic [7:0]          third_status_byte,
    output var  logic                quad_peripheral_mode,
    output var  logic [5:0]          read_dummy_clocks
);

    // ---------------- system clock side ----------------

    logic       erase_susp;
    logic       prog_susp;
    logic       prog_failed;
    logic       erase_failed;
    logic [1:0] dummy_r;
    logic [1:0] drive_r;
    logic       quad_mode;
    logic       quad_meta;
    logic       quad_sync;

    // suspend flags: a suspend in the resume cycle wins
    wire next_erase_susp  = erase_suspend   | (erase_susp & ~erase_resume);
    wire next_prog_susp   = program_suspend | (prog_susp & ~program_resume);

    // failure flags: a fresh failure in the clear cycle wins
    wire prog_fail_set    = program_fail | program_protected;
    wire erase_fail_set   = erase_fail | erase_protected;
    wire next_prog_failed = prog_fail_set  | (prog_failed  & ~fail_clear);
    wire next_erase_failed = erase_fail_set | (erase_failed & ~fail_clear);

    // assembled bytes, reserved positions tied low
    logic [7:0] next_second;
    logic [7:0] next_third;
    always_comb begin
        next_second                 = fsr_pkg::S2_RESET;
        next_second[fsr_pkg::S2_WIP] = write_in_progress;
        next_second[fsr_pkg::S2_ERASE_SUSP] = erase_susp;
        next_second[fsr_pkg::S2_PROG_SUSP]  = prog_susp;
        next_second[fsr_pkg::S2_PROG_FAIL]  = prog_failed;
        next_second[fsr_pkg::S2_ERASE_FAIL] = erase_failed;
        next_third = 8'h00;
        next_third[fsr_pkg::S3_DRIVE_LSB +: 2] = drive_r;
        next_third[fsr_pkg::S3_DUMMY_LSB +: 2] = dummy_r;
    end

    // volatile state, all cleared by reset
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            erase_susp   <= 1'b0;
            prog_susp    <= 1'b0;
            prog_failed  <= 1'b0;
            erase_failed <= 1'b0;
            dummy_r      <= fsr_pkg::S3_DUMMY_RESET;
            drive_r      <= fsr_pkg::S3_DRIVE_RESET;
        end else begin
            erase_susp   <= next_erase_susp;
            prog_susp    <= next_prog_susp;
            prog_failed  <= next_prog_failed;
            erase_failed <= next_erase_failed;
            dummy_r      <= dummy_code;
            drive_r      <= drive_code;
        end
    end

    // published copies and link mode brought home
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            second_status_byte   <= fsr_pkg::S2_RESET;
            third_status_byte    <= 8'h00;
            quad_meta            <= 1'b0;
            quad_sync            <= 1'b0;
            quad_peripheral_mode <= 1'b0;
            read_dummy_clocks    <= 6'h00;
        end else begin
            second_status_byte   <= next_second;
            third_status_byte    <= next_third;
            quad_meta            <= quad_mode;
            quad_sync            <= quad_meta;
            quad_peripheral_mode <= quad_sync;
            read_dummy_clocks    <= fsr_pkg::fsr_dummy_clocks(dummy_r, quad_sync);
        end
    end

    // ---------------- link clock side ----------------

    logic [7:0]       s2_meta;
    logic [7:0]       s2_sync;
    logic [7:0]       s3_meta;
    logic [7:0]       s3_sync;
    logic [2:0]       in_cnt;
    logic [7:0]       op_sr;
    logic             op_done;
    fsr_pkg::fsr_sel_t sel;
    logic [7:0]       out_sr;
    logic [2:0]       out_cnt;
    logic [3:0]       dq_o_r;
    logic [3:0]       dq_oe_n_r;

    // each status bit is an independent level, so a per-bit
    // two-stage sync is enough; the link clock only runs in frames,
    // so the copy can trail by up to two link edges after chip select
    always_ff @(posedge bus.sclk or posedge sys_rst) begin
        if (sys_rst) begin
            s2_meta <= 8'h00;
            s2_sync <= 8'h00;
            s3_meta <= 8'h00;
            s3_sync <= 8'h00;
        end else begin
            s2_meta <= second_status_byte;
            s2_sync <= s2_meta;
            s3_meta <= third_status_byte;
            s3_sync <= s3_meta;
        end
    end

    // opcode capture on rising edges, one or four lines
    wire [7:0] next_op  = quad_mode ? {op_sr[3:0], bus.dq}
                                    : {op_sr[6:0], bus.dq[0]};
    wire       op_last  = in_cnt == (quad_mode ? fsr_pkg::LAST_BIT_QUAD
                                               : fsr_pkg::LAST_BIT_SINGLE);
    wire       op_taken = ~op_done & op_last;
    wire fsr_pkg::fsr_sel_t next_sel =
        (next_op == fsr_pkg::OP_READ_SECOND) ? fsr_pkg::FSR_SEL_SECOND :
        (next_op == fsr_pkg::OP_READ_THIRD)  ? fsr_pkg::FSR_SEL_THIRD  :
                                               fsr_pkg::FSR_SEL_NONE;

    // frame state ends with chip select, not with a clock edge
    always_ff @(posedge bus.sclk or posedge bus.cs_n or posedge sys_rst) begin
        if (sys_rst || bus.cs_n) begin
            in_cnt  <= 3'h0;
            op_sr   <= 8'h00;
            op_done <= 1'b0;
            sel     <= fsr_pkg::FSR_SEL_NONE;
        end else if (!op_done) begin
            op_sr  <= next_op;
            in_cnt <= in_cnt + 3'h1;
            if (op_last) begin
                op_done <= 1'b1;
                sel     <= next_sel;   // reads accepted in any write state
            end
        end
    end

    // quad mode kept until reset; no exit path in this block
    always_ff @(posedge bus.sclk or posedge sys_rst) begin
        if (sys_rst) begin
            quad_mode <= 1'b0;
        end else if (op_taken && !quad_mode && next_op == fsr_pkg::OP_ENTER_QUAD) begin
            quad_mode <= 1'b1;
        end
    end

    // output shifter: reload a fresh byte at every byte boundary
    wire [7:0] sel_byte = (sel == fsr_pkg::FSR_SEL_SECOND) ? s2_sync : s3_sync;
    wire [2:0] out_last = quad_mode ? fsr_pkg::LAST_BIT_QUAD : fsr_pkg::LAST_BIT_SINGLE;
    wire [7:0] next_sr  = (out_cnt == 3'h0) ? sel_byte
                        : quad_mode ? {out_sr[3:0], 4'h0}
                                    : {out_sr[6:0], 1'b0};
    wire [3:0] next_dq  = quad_mode ? next_sr[7:4]
                                    : {2'h0, next_sr[7], 1'b0};
    wire [3:0] next_oe  = quad_mode ? 4'h0 : 4'hD;
    wire       sending  = sel != fsr_pkg::FSR_SEL_NONE;

    // falling edges drive data; chip select high releases at once
    always_ff @(negedge bus.sclk or posedge bus.cs_n or posedge sys_rst) begin
        if (sys_rst || bus.cs_n) begin
            out_sr    <= 8'h00;
            out_cnt   <= 3'h0;
            dq_o_r    <= 4'h0;
            dq_oe_n_r <= 4'hF;
        end else if (sending) begin
            out_sr    <= next_sr;
            out_cnt   <= (out_cnt == out_last) ? 3'h0 : out_cnt + 3'h1;
            dq_o_r    <= next_dq;
            dq_oe_n_r <= next_oe;
        end
    end

    assign bus.dev_dq_o    = dq_o_r;
    assign bus.dev_dq_oe_n = dq_oe_n_r;

endmodule : fsr_flash_end
`default_nettype wire

// file: design/fsr_host_end.sv
`timescale 1ns/1ps
`default_nettype none
module fsr_host_end #(
    parameter int HALF_DIV = 4
) (
    input  wire logic                clk,
    input  wire logic                sys_rst,
    fsr_spi_if.host                  bus,
    input  wire logic                start,
    input  wire fsr_pkg::fsr_cmd_t   cmd,
    input  wire logic [7:0]          read_count,
    input  wire logic                poll_until_idle,
    output var  logic                busy,
    output var  logic [7:0]          rx_data,
    output var  logic                rx_valid,
    output var  logic                quad_peripheral_mode,
    output var  logic [5:0]          read_dummy_clocks
);

    typedef enum logic [1:0] {H_IDLE, H_OP, H_DATA, H_END} fsr_hstate_t;

    fsr_hstate_t       state;
    logic [7:0]        hc;
    logic              sclk_r;
    logic              cs_n_r;
    logic [7:0]        tx_sr;
    logic [3:0]        dq_o_r;
    logic [3:0]        oe_n_r;
    logic [2:0]        bits;
    logic              seg_done;
    logic [7:0]        rx_sr;
    logic [7:0]        left;
    fsr_pkg::fsr_cmd_t cmd_r;
    logic              poll_r;
    logic [3:0]        dq_meta;
    logic [3:0]        dq_sync;

    // divider; HALF_DIV must be 3 or more so synced data settles
    wire tick    = hc == 8'(HALF_DIV - 1);
    wire rising  = tick & ~sclk_r & (state == H_OP || state == H_DATA);
    wire falling = tick &  sclk_r;
    wire quad    = quad_peripheral_mode;
    wire [2:0] last_bit = quad ? fsr_pkg::LAST_BIT_QUAD : fsr_pkg::LAST_BIT_SINGLE;

    wire [7:0] op_code = (cmd == fsr_pkg::FSR_CMD_READ_SECOND) ? fsr_pkg::OP_READ_SECOND
                       : (cmd == fsr_pkg::FSR_CMD_READ_THIRD)  ? fsr_pkg::OP_READ_THIRD
                                                               : fsr_pkg::OP_ENTER_QUAD;
    wire [7:0] shifted = quad ? {tx_sr[3:0], 4'h0} : {tx_sr[6:0], 1'b0};
    wire [3:0] first_dq = quad ? op_code[7:4] : {3'h0, op_code[7]};
    wire [3:0] next_dq  = quad ? shifted[7:4] : {3'h0, shifted[7]};
    wire [7:0] next_rx  = quad ? {rx_sr[3:0], dq_sync} : {rx_sr[6:0], dq_sync[1]};
    wire       second   = cmd_r == fsr_pkg::FSR_CMD_READ_SECOND;
    wire [7:0] rx_mask  = second ? fsr_pkg::S2_MASK : fsr_pkg::S3_MASK;
    // poll ends once the busy bit reads clear
    wire       rx_last  = (poll_r && second) ? ~next_rx[fsr_pkg::S2_WIP]
                                             : left == 8'h01;

    // data lines come from the other party: two stages first
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dq_meta <= 4'h0;
            dq_sync <= 4'h0;
        end else begin
            dq_meta <= bus.dq;
            dq_sync <= dq_meta;
        end
    end

    // frame sequencer
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= H_IDLE;
            hc <= 8'h00;
            sclk_r <= 1'b0;
            cs_n_r <= 1'b1;
            tx_sr <= 8'h00;
            dq_o_r <= 4'h0;
            oe_n_r <= 4'hF;
            bits <= 3'h0;
            seg_done <= 1'b0;
            rx_sr <= 8'h00;
            left <= 8'h00;
            cmd_r <= fsr_pkg::FSR_CMD_READ_SECOND;
            poll_r <= 1'b0;
            busy <= 1'b0;
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
            quad_peripheral_mode <= 1'b0;
            read_dummy_clocks <= 6'h00;
        end else begin
            rx_valid <= 1'b0;
            hc <= (tick || state == H_IDLE) ? 8'h00 : hc + 8'h01;
            if (tick && (state == H_OP || state == H_DATA)) begin
                sclk_r <= ~sclk_r;
            end
            unique case (state)
                H_IDLE: if (start) begin
                    state <= H_OP;
                    busy <= 1'b1;
                    cs_n_r <= 1'b0;
                    tx_sr <= op_code;
                    dq_o_r <= first_dq;
                    oe_n_r <= quad ? 4'h0 : 4'hE;
                    cmd_r <= cmd;
                    poll_r <= poll_until_idle;
                    left <= (read_count == 8'h00) ? 8'h01 : read_count;
                    bits <= 3'h0;
                    seg_done <= 1'b0;
                end
                H_OP: begin
                    if (rising) begin
                        bits <= bits + 3'h1;
                        seg_done <= bits == last_bit;
                    end else if (falling && seg_done) begin
                        oe_n_r <= 4'hF;
                        bits <= 3'h0;
                        seg_done <= 1'b0;
                        if (cmd_r == fsr_pkg::FSR_CMD_ENTER_QUAD) begin
                            state <= H_END;
                            quad_peripheral_mode <= 1'b1;
                        end else begin
                            state <= H_DATA;
                        end
                    end else if (falling) begin
                        tx_sr <= shifted;
                        dq_o_r <= next_dq;
                    end
                end
                H_DATA: begin
                    if (rising) begin
                        rx_sr <= next_rx;
                        bits <= (bits == last_bit) ? 3'h0 : bits + 3'h1;
                        if (bits == last_bit) begin
                            rx_valid <= 1'b1;
                            rx_data <= next_rx & rx_mask;
                            left <= left - 8'h01;
                            seg_done <= rx_last;
                            if (!second) begin
                                read_dummy_clocks <= fsr_pkg::fsr_dummy_clocks(
                                    next_rx[fsr_pkg::S3_DUMMY_LSB +: 2], quad);
                            end
                        end
                    end else if (falling && seg_done) begin
                        state <= H_END;
                    end
                end
                H_END: if (tick) begin
                    state <= H_IDLE;
                    cs_n_r <= 1'b1;
                    busy <= 1'b0;
                end
            endcase
        end
    end

    assign bus.sclk         = sclk_r;
    assign bus.cs_n         = cs_n_r;
    assign bus.host_dq_o    = dq_o_r;
    assign bus.host_dq_oe_n = oe_n_r;

endmodule : fsr_host_end
`default_nettype wire

// file: design/fsr_pkg.sv
`default_nettype none
package fsr_pkg;

    // opcodes seen on the link
    localparam logic [7:0] OP_READ_SECOND = 8'h09;
    localparam logic [7:0] OP_READ_THIRD  = 8'h95;
    localparam logic [7:0] OP_ENTER_QUAD  = 8'h38;
    localparam logic [7:0] OP_FAST_READ   = 8'h0B;
    localparam logic [7:0] OP_QUAD_IO_RD  = 8'hEB;

    // second status byte layout
    localparam int S2_WIP         = 0;
    localparam int S2_ERASE_SUSP  = 2;
    localparam int S2_PROG_SUSP   = 3;
    localparam int S2_PROG_FAIL   = 5;
    localparam int S2_ERASE_FAIL  = 6;
    localparam logic [7:0] S2_RESET = 8'h00;
    localparam logic [7:0] S2_MASK  = 8'h6D;

    // third status byte layout
    localparam int S3_DRIVE_LSB = 2;
    localparam int S3_DUMMY_LSB = 4;
    localparam logic [7:0] S3_MASK        = 8'h3C;
    localparam logic [1:0] S3_DUMMY_RESET = 2'h0;
    localparam logic [1:0] S3_DRIVE_RESET = 2'h0;

    // dummy byte codes
    localparam logic [1:0] DUMMY_3B = 2'h0;
    localparam logic [1:0] DUMMY_2B = 2'h1;
    localparam logic [1:0] DUMMY_4B = 2'h2;
    localparam logic [1:0] DUMMY_5B = 2'h3;
    localparam logic [3:0] CLK_PER_BYTE_QUAD   = 4'h2;
    localparam logic [3:0] CLK_PER_BYTE_SINGLE = 4'h8;
    localparam int FAST_READ_MAX_MHZ = 104;

    // last link clock index of a byte, on one line and on four
    localparam logic [2:0] LAST_BIT_SINGLE = 3'h7;
    localparam logic [2:0] LAST_BIT_QUAD   = 3'h1;

    typedef enum logic [1:0] {
        FSR_SEL_NONE,
        FSR_SEL_SECOND,
        FSR_SEL_THIRD
    } fsr_sel_t;

    typedef enum logic [1:0] {
        FSR_CMD_READ_SECOND,
        FSR_CMD_READ_THIRD,
        FSR_CMD_ENTER_QUAD
    } fsr_cmd_t;

    // dummy byte count for a code
    function automatic logic [2:0] fsr_dummy_bytes(input logic [1:0] code);
        unique case (code)
            DUMMY_3B: fsr_dummy_bytes = 3'h3;
            DUMMY_2B: fsr_dummy_bytes = 3'h2;
            DUMMY_4B: fsr_dummy_bytes = 3'h4;
            DUMMY_5B: fsr_dummy_bytes = 3'h5;
        endcase
    endfunction : fsr_dummy_bytes

    // dummy clocks: two per byte on four lines, eight on one
    function automatic logic [5:0] fsr_dummy_clocks(input logic [1:0] code,
                                                    input logic       quad);
        logic [6:0] prod;
        prod = fsr_dummy_bytes(code) * (quad ? CLK_PER_BYTE_QUAD : CLK_PER_BYTE_SINGLE);
        fsr_dummy_clocks = prod[5:0];
    endfunction : fsr_dummy_clocks

    // fast reads: unaligned start needs 3 bytes, word or dword start 2
    function automatic logic [1:0] fsr_dummy_for_addr(input logic addr_bit0);
        fsr_dummy_for_addr = addr_bit0 ? DUMMY_3B : DUMMY_2B;
    endfunction : fsr_dummy_for_addr

endpackage : fsr_pkg
`default_nettype wire

// file: design/fsr_spi_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fsr_spi_if;
    logic       sclk;
    logic       cs_n;
    logic [3:0] host_dq_o;
    logic [3:0] host_dq_oe_n;
    logic [3:0] dev_dq_o;
    logic [3:0] dev_dq_oe_n;
    logic [3:0] dq;

    // wire level: whoever enables drives, otherwise pulled high
    assign dq = (~dev_dq_oe_n & dev_dq_o) | (~host_dq_oe_n & host_dq_o)
              | (dev_dq_oe_n & host_dq_oe_n);

    modport host (
        output sclk,
        output cs_n,
        output host_dq_o,
        output host_dq_oe_n,
        input  dq
    );
    modport device (
        input  sclk,
        input  cs_n,
        input  dq,
        output dev_dq_o,
        output dev_dq_oe_n
    );
endinterface : fsr_spi_if
`default_nettype wire

// file: testbench/fsr_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module fsr_link_asserts (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       sclk,
    input wire logic       cs_n,
    input wire logic [3:0] host_dq_oe_n,
    input wire logic [3:0] dev_dq_o,
    input wire logic [3:0] dev_dq_oe_n
);
    logic [3:0] n_rise;

    // rising link edges in this frame, saturating so long polls never wrap
    always_ff @(posedge sclk or posedge cs_n or posedge sys_rst) begin
        if (cs_n || sys_rst) begin
            n_rise <= 4'h0;
        end else if (n_rise != 4'hF) begin
            n_rise <= n_rise + 4'h1;
        end
    end

    default clocking dc @(posedge clk); endclocking
    default disable iff (sys_rst);

    idle_sclk_a: assert property (cs_n |-> !sclk)
        else $error("link clock not idle low outside frame");
    idle_release_a: assert property (cs_n |-> dev_dq_oe_n == 4'hF)
        else $error("device drives with chip select high");
    release_cs_a: assert property ($rose(dev_dq_oe_n[1]) |-> cs_n)
        else $error("device let go of the line inside a frame");
    no_clash_a: assert property ((~dev_dq_oe_n & ~host_dq_oe_n) == 4'h0)
        else $error("both ends drive one line");
    dev_lanes_a: assert property (dev_dq_oe_n inside {4'hF, 4'hD, 4'h0})
        else $error("device drives an odd set of lines");
    launch_fall_a: assert property ($fell(dev_dq_oe_n[1]) |-> $fell(sclk))
        else $error("device began driving off a falling link edge");
    hold_high_a: assert property (sclk |-> $stable(dev_dq_o))
        else $error("device data moved while link clock high");
    single_quiet_a: assert property (dev_dq_oe_n == 4'hD |-> n_rise >= 4'h8)
        else $error("single line answer before full opcode");
    quad_quiet_a: assert property (dev_dq_oe_n == 4'h0 |-> n_rise >= 4'h2)
        else $error("quad answer before full opcode");
endmodule : fsr_link_asserts
`default_nettype wire

// file: testbench/tb_flash_status_regs_two_three.sv
`timescale 1ns/1ps
`default_nettype none
module tb_flash_status_regs_two_three;
    logic              clk, sys_rst, write_in_progress, start, busy, rx_valid, hq, dq_mode, poll;
    logic [8:0]        evt;
    logic [1:0]        dummy_code, drive_code;
    logic [7:0]        read_count, rx_data, s2, s3;
    logic [5:0]        hdc, ddc;
    fsr_pkg::fsr_cmd_t cmd;
    int                n_errors, n_tests;
    int                cyc = 0;
    // event pulses and the second byte expected after each
    logic [8:0] ev_tab [10] = '{9'h001, 9'h004, 9'h002, 9'h008, 9'h010,
                                9'h020, 9'h100, 9'h040, 9'h180, 9'h100};
    logic [7:0] s2_tab [10] = '{8'h04, 8'h0C, 8'h08, 8'h00, 8'h20,
                                8'h60, 8'h00, 8'h20, 8'h40, 8'h00};
    int dby [4] = '{3, 2, 4, 5};

    fsr_spi_if fsr_spi_if_inst ();
    fsr_flash_end fsr_flash_end_inst (.clk(clk), .sys_rst(sys_rst), .bus(fsr_spi_if_inst),
        .write_in_progress(write_in_progress), .erase_suspend(evt[0]), .erase_resume(evt[1]), .program_suspend(evt[2]),
        .program_resume(evt[3]), .program_fail(evt[4]), .erase_fail(evt[5]),
        .program_protected(evt[6]), .erase_protected(evt[7]), .fail_clear(evt[8]),
        .dummy_code(dummy_code), .drive_code(drive_code), .second_status_byte(s2),
        .third_status_byte(s3), .quad_peripheral_mode(dq_mode), .read_dummy_clocks(ddc));
    fsr_host_end #(.HALF_DIV(4)) fsr_host_end_inst (.clk(clk), .sys_rst(sys_rst),
        .bus(fsr_spi_if_inst), .start(start), .cmd(cmd), .read_count(read_count),
        .poll_until_idle(poll), .busy(busy), .rx_data(rx_data), .rx_valid(rx_valid),
        .quad_peripheral_mode(hq), .read_dummy_clocks(hdc));
    fsr_link_asserts fsr_link_asserts_inst (.clk(clk), .sys_rst(sys_rst),
        .sclk(fsr_spi_if_inst.sclk), .cs_n(fsr_spi_if_inst.cs_n),
        .host_dq_oe_n(fsr_spi_if_inst.host_dq_oe_n), .dev_dq_o(fsr_spi_if_inst.dev_dq_o),
        .dev_dq_oe_n(fsr_spi_if_inst.dev_dq_oe_n));

    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    // one framed command; every byte is compared, then the byte count
    task automatic rd(input fsr_pkg::fsr_cmd_t c, input int n, input logic [7:0] exp);
        int got, w;
        got = 0;
        w = 0;
        @(posedge clk);
        cmd <= c;
        read_count <= 8'(n);
        start <= 1'h1;
        @(posedge clk);
        start <= 1'h0;
        do begin
            @(posedge clk);
            #1;
            if (rx_valid === 1'h1) begin
                chk(rx_data, exp);
                got++;
            end
            w++;
        end while (busy === 1'h1 && w < 3000);
        chk(8'(got), 8'(n));
    endtask : rd

    // pulse, then look two edges after the pulse edge
    task automatic ev(input logic [8:0] e);
        @(posedge clk);
        evt <= e;
        @(posedge clk);
        evt <= 9'h000;
        @(posedge clk);
        #1;
    endtask : ev

    task automatic t_reset();
        chk(s2, 8'h00);
        chk(s3, 8'h00);
        chk({5'h0, fsr_pkg::fsr_dummy_bytes(fsr_pkg::fsr_dummy_for_addr(1'h1))}, 8'h03);
        chk({5'h0, fsr_pkg::fsr_dummy_bytes(fsr_pkg::fsr_dummy_for_addr(1'h0))}, 8'h02);
        rd(fsr_pkg::FSR_CMD_READ_SECOND, 1, 8'h00);
        rd(fsr_pkg::FSR_CMD_READ_THIRD, 1, 8'h00);
        $display("reset test done");
    endtask : t_reset

    task automatic t_busy();
        @(posedge clk);
        write_in_progress <= 1'h1;
        repeat (3) @(posedge clk);
        #1;
        chk(s2, 8'h01);
        rd(fsr_pkg::FSR_CMD_READ_SECOND, 3, 8'h01);
        @(posedge clk);
        write_in_progress <= 1'h0;
        $display("busy test done");
    endtask : t_busy

    task automatic t_events();
        for (int i = 0; i < 10; i++) begin
            ev(ev_tab[i]);
            chk(s2, s2_tab[i]);
            rd(fsr_pkg::FSR_CMD_READ_SECOND, 1, s2_tab[i]);
        end
        $display("event test done");
    endtask : t_events

    // all dummy codes; quad mode takes two clocks per byte instead of eight
    task automatic t_third(input int per);
        logic [7:0] e3;
        for (int d = 0; d < 4; d++) begin
            @(posedge clk);
            dummy_code <= 2'(d);
            drive_code <= ~2'(d);
            repeat (4) @(posedge clk);
            e3 = {2'h0, 2'(d), ~2'(d), 2'h0};
            chk(s3, e3);
            rd(fsr_pkg::FSR_CMD_READ_THIRD, 2, e3);
            chk({2'h0, hdc}, 8'(dby[d] * per));
            chk({2'h0, ddc}, 8'(dby[d] * per));
        end
        $display("third byte test done");
    endtask : t_third

    task automatic t_quad();
        rd(fsr_pkg::FSR_CMD_ENTER_QUAD, 0, 8'h00);
        chk({7'h0, hq}, 8'h01);
        repeat (8) @(posedge clk);
        #1;
        chk({7'h0, dq_mode}, 8'h01);
        @(posedge clk);
        write_in_progress <= 1'h1;
        ev(9'h001);
        chk(s2, 8'h05);
        rd(fsr_pkg::FSR_CMD_READ_SECOND, 2, 8'h05);
        t_third(2);
        $display("quad test done");
    endtask : t_quad

    // poll while busy; busy drops mid-stream, frame must end on a clear byte
    task automatic t_poll();
        int w;
        logic [7:0] last;
        w = 0;
        last = 8'hFF;
        @(posedge clk);
        write_in_progress <= 1'h1;
        cmd <= fsr_pkg::FSR_CMD_READ_SECOND;
        poll <= 1'h1;
        start <= 1'h1;
        @(posedge clk);
        start <= 1'h0;
        poll <= 1'h0;
        do begin
            @(posedge clk);
            if (w == 600) write_in_progress <= 1'h0;
            #1;
            if (rx_valid === 1'h1) last = rx_data;
            w++;
        end while (busy === 1'h1 && w < 3000);
        chk(last, 8'h00);
        chk(8'(w > 600), 8'h01);
        $display("poll test done");
    endtask : t_poll

    // reset mid-run: quad mode and every flag must drop
    task automatic t_rerun();
        @(posedge clk);
        sys_rst <= 1'h1;
        write_in_progress <= 1'h0;
        dummy_code <= 2'h0;
        drive_code <= 2'h0;
        repeat (6) @(posedge clk);
        sys_rst <= 1'h0;
        #1;
        chk({7'h0, dq_mode}, 8'h00);
        chk({7'h0, hq}, 8'h00);
        t_reset();
        $display("rerun test done");
    endtask : t_rerun

    // hang guard, well above the expected run length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_errors++;
            $display("mismatch at %0t: timeout", $time);
            close_out();
        end
    end

    initial begin
        sys_rst = 1'h1;
        write_in_progress = 1'h0;
        start = 1'h0;
        poll = 1'h0;
        evt = 9'h000;
        cmd = fsr_pkg::FSR_CMD_READ_SECOND;
        read_count = 8'h00;
        dummy_code = 2'h0;
        drive_code = 2'h0;
        n_errors = 0;
        n_tests = 0;
        repeat (6) @(posedge clk);
        sys_rst <= 1'h0;
        t_reset();
        t_busy();
        t_events();
        t_poll();
        t_third(8);
        t_quad();
        t_rerun();
        close_out();
    end
endmodule : tb_flash_status_regs_two_three
`default_nettype wire
